/* File: include/dos_pkg.sv */
// Package: constants and types for the drive operating state sequencer
package dos_pkg;

  // ----------------------------------------------------------------
  // Bus register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] CTRL_OFS   = 4'h0;
  localparam logic [3:0] CFG_OFS    = 4'h4;
  localparam logic [3:0] STAT_OFS   = 4'h8;
  localparam logic [3:0] PWRITE_OFS = 4'hC;

  // ----------------------------------------------------------------
  // Control word fields
  // ----------------------------------------------------------------
  localparam int CW_SWITCH_ON  = 0;
  localparam int CW_EN_VOLT    = 1;
  localparam int CW_QSTOP_N    = 2;
  localparam int CW_EN_OP      = 3;
  localparam int CW_FAULT_RST  = 7;
  localparam int CW_HALT       = 8;
  localparam int CW_FREEWHEEL  = 11;

  // ----------------------------------------------------------------
  // Configuration register fields
  // ----------------------------------------------------------------
  localparam int CFG_STOP_SEL  = 0;
  localparam int CFG_QS_HOLD   = 1;
  localparam int CFG_SEP_CTRL  = 2;
  localparam int CFG_CONTACTOR = 3;
  localparam int CFG_REF_CHAN  = 4;
  localparam int CFG_W         = 5;

  // Parameter-write register: bit 0 config, bit 1 adjustment
  localparam int PW_CONFIG     = 0;
  localparam int PW_ADJUST     = 1;

  // ----------------------------------------------------------------
  // Reset values and state word codes
  // ----------------------------------------------------------------
  localparam logic [15:0]        CTRL_RST = 16'h0000;
  localparam logic [CFG_W-1:0]   CFG_RST  = 5'h00;
  localparam logic [3:0]         SW_INIT  = 4'h1;
  localparam logic [3:0]         SW_DIS   = 4'h2;
  localparam logic [3:0]         SW_RDY   = 4'h3;
  localparam logic [3:0]         SW_ON    = 4'h4;
  localparam logic [3:0]         SW_OPEN  = 4'h5;
  localparam logic [3:0]         SW_QSTOP = 4'h6;
  localparam logic [3:0]         SW_FREACT= 4'h7;
  localparam logic [3:0]         SW_FAULT = 4'h8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ       = 100;
  localparam int INIT_TIME_NS  = 100;
  localparam int INIT_CYCLES   = (INIT_TIME_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [3:0] {
    DOS_INIT, DOS_DISABLED, DOS_READY, DOS_SWITCHED_ON, DOS_OP_ENABLED,
    DOS_OP_STOPPING, DOS_QUICK_STOP, DOS_FAULT_REACT, DOS_FAULT
  } dos_state_t;

endpackage

/* File: src/dos_sequencer.sv */
// Drive operating state sequencer with Avalon-MM register slave
//
// Decided for this implementation: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none

module dos_sequencer (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Drive events
  input  wire logic        power_supply_ok,
  input  wire logic        channel_valid,
  input  wire logic        reference_rx,
  input  wire logic        reference_zero,
  input  wire logic        ramp_done,
  input  wire logic        fault_detect,
  input  wire logic        fault_resp_done,
  input  wire logic        stop_key,
  input  wire logic        term_freewheel,
  input  wire logic        autotune_req,
  // Drive controls
  output logic [3:0]       drive_state_word,
  output logic             power_stage_ready,
  output logic             motor_power,
  output logic             output_voltage,
  output logic             contactor_close,
  output logic             ramp_decel,
  output logic             fast_ramp,
  output logic             coast,
  output logic             config_write_ok,
  output logic             adjust_write_ok,
  output logic             autotune_start
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  dos_pkg::dos_state_t     state_q;
  logic [15:0]             ctrl_q;
  logic [dos_pkg::CFG_W-1:0] quick_stop_behaviour_q;
  logic                    fault_rst_prev_q;
  logic                    ref_seen_q;
  logic                    cfg_write_q;
  logic [7:0]              init_cnt_q;
  logic                    ack_q;
  logic                    disable_op_stop_select;
  logic                    quick_stop_hold;

  assign disable_op_stop_select = quick_stop_behaviour_q[dos_pkg::CFG_STOP_SEL];
  assign quick_stop_hold        = quick_stop_behaviour_q[dos_pkg::CFG_QS_HOLD];

  function automatic logic [3:0] state_code(input dos_pkg::dos_state_t s);
    case (s)
      dos_pkg::DOS_DISABLED:    state_code = dos_pkg::SW_DIS;
      dos_pkg::DOS_READY:       state_code = dos_pkg::SW_RDY;
      dos_pkg::DOS_SWITCHED_ON: state_code = dos_pkg::SW_ON;
      dos_pkg::DOS_OP_ENABLED,
      dos_pkg::DOS_OP_STOPPING: state_code = dos_pkg::SW_OPEN;
      dos_pkg::DOS_QUICK_STOP:  state_code = dos_pkg::SW_QSTOP;
      dos_pkg::DOS_FAULT_REACT: state_code = dos_pkg::SW_FREACT;
      dos_pkg::DOS_FAULT:       state_code = dos_pkg::SW_FAULT;
      // Initialisation is hidden: report switch-on disabled
      default:                  state_code = dos_pkg::SW_DIS;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Bus slave: one wait cycle, answer on the second edge
  // ----------------------------------------------------------------
  logic bus_req;
  logic bus_take;
  assign bus_req  = avs_read | avs_write;
  assign bus_take = bus_req & ack_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req & ~ack_q;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~(bus_req & ~ack_q);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~ack_q) begin
      case (avs_address)
        dos_pkg::CTRL_OFS:  avs_readdata <= {16'h0000, ctrl_q};
        dos_pkg::CFG_OFS:   avs_readdata <= {27'h000_0000, quick_stop_behaviour_q};
        dos_pkg::STAT_OFS:  avs_readdata <= {28'h000_0000, state_code(state_q)};
        default:            avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  logic cfg_allowed;
  assign cfg_allowed = (state_q == dos_pkg::DOS_DISABLED) || (state_q == dos_pkg::DOS_READY)
                     || (state_q == dos_pkg::DOS_SWITCHED_ON) || (state_q == dos_pkg::DOS_FAULT);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= dos_pkg::CTRL_RST;
    end else if (avs_write & bus_take & (avs_address == dos_pkg::CTRL_OFS)) begin
      if (avs_byteenable[0]) ctrl_q[7:0]  <= avs_writedata[7:0];
      if (avs_byteenable[1]) ctrl_q[15:8] <= avs_writedata[15:8];
    end
  end

  // Configuration writes are refused in states 1, 5, 6 and 7
  logic cfg_wr;
  assign cfg_wr = avs_write & bus_take & avs_byteenable[0] & cfg_allowed &
                  (((avs_address == dos_pkg::CFG_OFS)) ||
                   ((avs_address == dos_pkg::PWRITE_OFS) & avs_writedata[dos_pkg::PW_CONFIG]));

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      quick_stop_behaviour_q <= dos_pkg::CFG_RST;
    end else if (cfg_wr & (avs_address == dos_pkg::CFG_OFS)) begin
      quick_stop_behaviour_q <= avs_writedata[dos_pkg::CFG_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_write_q <= 1'b0;
    end else begin
      cfg_write_q <= cfg_wr;
    end
  end

  // ----------------------------------------------------------------
  // Event qualifiers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_seen_q <= 1'b0;
    end else if (reference_rx) begin
      ref_seen_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_rst_prev_q <= 1'b0;
    end else begin
      fault_rst_prev_q <= ctrl_q[dos_pkg::CW_FAULT_RST];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      init_cnt_q <= 8'h00;
    end else if (state_q == dos_pkg::DOS_INIT) begin
      init_cnt_q <= init_cnt_q + 8'h01;
    end
  end

  logic cmd_shutdown;
  logic cmd_switch_on;
  logic cmd_enable_op;
  logic cmd_dis_volt;
  logic cmd_qstop;
  logic fault_reset;
  logic freewheel;
  logic enable_ok;
  logic supply_ok;
  logic operational;

  assign cmd_dis_volt  = ~ctrl_q[dos_pkg::CW_EN_VOLT];
  assign cmd_qstop     = ctrl_q[dos_pkg::CW_EN_VOLT] & ~ctrl_q[dos_pkg::CW_QSTOP_N];
  assign cmd_shutdown  = ctrl_q[dos_pkg::CW_EN_VOLT] & ctrl_q[dos_pkg::CW_QSTOP_N]
                       & ~ctrl_q[dos_pkg::CW_SWITCH_ON];
  assign cmd_switch_on = ctrl_q[dos_pkg::CW_EN_VOLT] & ctrl_q[dos_pkg::CW_QSTOP_N]
                       & ctrl_q[dos_pkg::CW_SWITCH_ON];
  assign cmd_enable_op = cmd_switch_on & ctrl_q[dos_pkg::CW_EN_OP];
  assign fault_reset   = ctrl_q[dos_pkg::CW_FAULT_RST] & ~fault_rst_prev_q;
  assign freewheel     = term_freewheel | ctrl_q[dos_pkg::CW_FREEWHEEL];
  // Channel must be valid; a shared reference channel needs one reference first
  assign enable_ok     = channel_valid &
                         (~quick_stop_behaviour_q[dos_pkg::CFG_REF_CHAN] | ref_seen_q);
  // Integrated supply stages always count as supplied here
  assign supply_ok     = power_supply_ok | ~quick_stop_behaviour_q[dos_pkg::CFG_SEP_CTRL];
  assign operational   = (state_q == dos_pkg::DOS_SWITCHED_ON) || (state_q == dos_pkg::DOS_OP_ENABLED)
                       || (state_q == dos_pkg::DOS_OP_STOPPING) || (state_q == dos_pkg::DOS_QUICK_STOP);

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= dos_pkg::DOS_INIT;
    end else if (fault_detect & operational) begin
      state_q <= dos_pkg::DOS_FAULT_REACT;
    end else begin
      case (state_q)
        dos_pkg::DOS_INIT: begin
          if (init_cnt_q >= 8'(dos_pkg::INIT_CYCLES - 1))
            state_q <= dos_pkg::DOS_DISABLED;
        end
        dos_pkg::DOS_DISABLED: begin
          if (cmd_shutdown & ~freewheel) state_q <= dos_pkg::DOS_READY;
        end
        dos_pkg::DOS_READY: begin
          if (cmd_dis_volt | cmd_qstop | freewheel) state_q <= dos_pkg::DOS_DISABLED;
          else if (cmd_switch_on & supply_ok) state_q <= dos_pkg::DOS_SWITCHED_ON;
        end
        dos_pkg::DOS_SWITCHED_ON: begin
          if (cmd_dis_volt | cmd_qstop | freewheel | cfg_write_q)
            state_q <= dos_pkg::DOS_DISABLED;
          else if (cmd_shutdown) state_q <= dos_pkg::DOS_READY;
          else if (cmd_enable_op & enable_ok) state_q <= dos_pkg::DOS_OP_ENABLED;
        end
        dos_pkg::DOS_OP_ENABLED: begin
          if (cmd_dis_volt | freewheel) state_q <= dos_pkg::DOS_DISABLED;
          else if (cmd_qstop) state_q <= dos_pkg::DOS_QUICK_STOP;
          else if (cmd_shutdown) state_q <= dos_pkg::DOS_READY;
          else if (cmd_switch_on & ~ctrl_q[dos_pkg::CW_EN_OP]) begin
            if (disable_op_stop_select) state_q <= dos_pkg::DOS_OP_STOPPING;
            else state_q <= dos_pkg::DOS_SWITCHED_ON;
          end
        end
        dos_pkg::DOS_OP_STOPPING: begin
          if (cmd_dis_volt | freewheel) state_q <= dos_pkg::DOS_DISABLED;
          else if (ramp_done) state_q <= dos_pkg::DOS_SWITCHED_ON;
        end
        dos_pkg::DOS_QUICK_STOP: begin
          if (cmd_dis_volt | stop_key | freewheel)
            state_q <= dos_pkg::DOS_DISABLED;
          else if (ramp_done & ~quick_stop_hold)
            state_q <= dos_pkg::DOS_DISABLED;
        end
        dos_pkg::DOS_FAULT_REACT: begin
          if (fault_resp_done) state_q <= dos_pkg::DOS_FAULT;
        end
        dos_pkg::DOS_FAULT: begin
          if (fault_reset & ~fault_detect) state_q <= dos_pkg::DOS_DISABLED;
        end
        default: state_q <= dos_pkg::DOS_DISABLED;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registered drive outputs, decoded from the state
  // ----------------------------------------------------------------
  logic run_st;
  logic qs_st;
  logic on_st;
  assign run_st = (state_q == dos_pkg::DOS_OP_ENABLED) || (state_q == dos_pkg::DOS_OP_STOPPING);
  assign qs_st  = (state_q == dos_pkg::DOS_QUICK_STOP) & ~ramp_done;
  assign on_st  = (state_q == dos_pkg::DOS_SWITCHED_ON) || run_st;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      drive_state_word  <= dos_pkg::SW_DIS;
      power_stage_ready <= 1'b0;
      motor_power       <= 1'b0;
      output_voltage    <= 1'b0;
      contactor_close   <= 1'b0;
      ramp_decel        <= 1'b0;
      fast_ramp         <= 1'b0;
      coast             <= 1'b0;
      config_write_ok   <= 1'b0;
      adjust_write_ok   <= 1'b0;
      autotune_start    <= 1'b0;
    end else begin
      drive_state_word  <= state_code(state_q);
      power_stage_ready <= on_st | (state_q == dos_pkg::DOS_QUICK_STOP);
      // Halt or zero reference removes torque but keeps state 5
      motor_power       <= (run_st & ~ctrl_q[dos_pkg::CW_HALT] & ~reference_zero)
                         | qs_st;
      output_voltage    <= run_st | qs_st;
      contactor_close   <= quick_stop_behaviour_q[dos_pkg::CFG_CONTACTOR] &
                           (on_st | (state_q == dos_pkg::DOS_QUICK_STOP));
      ramp_decel        <= state_q == dos_pkg::DOS_OP_STOPPING;
      fast_ramp         <= qs_st;
      coast             <= ~(run_st | qs_st);
      config_write_ok   <= cfg_allowed;
      adjust_write_ok   <= state_q != dos_pkg::DOS_INIT;
      autotune_start    <= autotune_req & (state_q == dos_pkg::DOS_OP_ENABLED);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_dis_op;
    state_q == dos_pkg::DOS_OP_ENABLED && cmd_switch_on && !ctrl_q[dos_pkg::CW_EN_OP]
      && !cmd_dis_volt && !freewheel && !cmd_qstop && !fault_detect;
  endsequence

  // Error response time is open-ended, so entry and exit are checked as separate steps
  sequence s_fault_hit;
    fault_detect && operational;
  endsequence

  sequence s_fault_end;
    state_q == dos_pkg::DOS_FAULT_REACT && fault_resp_done;
  endsequence

  hidden_init_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    drive_state_word != dos_pkg::SW_INIT) else $error("state 1 reported");
  init_exit_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    state_q == dos_pkg::DOS_INIT |-> ##[1:20] state_q == dos_pkg::DOS_DISABLED)
    else $error("init did not finish");
  cfg_fallback_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    state_q == dos_pkg::DOS_SWITCHED_ON && cfg_write_q && !fault_detect
    |=> state_q == dos_pkg::DOS_DISABLED) else $error("no fallback");
  coast_stop_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_dis_op and !disable_op_stop_select |=> state_q == dos_pkg::DOS_SWITCHED_ON)
    else $error("no coast stop");
  ramp_stop_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_dis_op and disable_op_stop_select |=> state_q == dos_pkg::DOS_OP_STOPPING)
    else $error("no ramp stop");
  enable_gate_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    state_q == dos_pkg::DOS_SWITCHED_ON && !channel_valid && !fault_detect
    |=> state_q != dos_pkg::DOS_OP_ENABLED) else $error("enable bad channel");
  halt_torque_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    run_st && ctrl_q[dos_pkg::CW_HALT] |=> !motor_power) else $error("halt power");
  fault_entry_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_fault_hit |=> state_q == dos_pkg::DOS_FAULT_REACT) else $error("fault entry");
  fault_exit_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_fault_end |=> state_q == dos_pkg::DOS_FAULT) else $error("fault exit");
  fault_lock_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    state_q == dos_pkg::DOS_FAULT |=> !power_stage_ready && !motor_power)
    else $error("fault not locked");
  cfg_keep_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    state_q == dos_pkg::DOS_OP_ENABLED && avs_write && bus_take
    && avs_address == dos_pkg::CFG_OFS |=> $stable(quick_stop_behaviour_q))
    else $error("config written in 5");
  tune_gate_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    autotune_start |-> $past(state_q) == dos_pkg::DOS_OP_ENABLED)
    else $error("tune outside 5");
  qs_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    state_q == dos_pkg::DOS_QUICK_STOP && quick_stop_hold && !cmd_dis_volt && !stop_key
    && !freewheel && !fault_detect |=> state_q == dos_pkg::DOS_QUICK_STOP)
    else $error("quick stop left");

endmodule // dos_sequencer

`default_nettype wire

/* File: test/dos_master.sv */
// Fieldbus master model issuing control words over Avalon-MM
`timescale 1ns/100ps
`default_nettype none

module dos_master (
  // Clock
  input  wire logic        core_clk,
  // Avalon-MM master side
  output logic [3:0]       avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [31:0]      avs_writedata,
  output logic [3:0]       avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  initial begin
    avs_address    = 4'h0;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0;
    avs_byteenable = 4'h0;
  end

  // Request held until waitrequest is sampled low at a rising edge
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge core_clk);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= 4'hF;
    avs_write      <= wr;
    avs_read       <= !wr;
    // Only the bench timeout ends an answer that never comes
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
endmodule // dos_master

`default_nettype wire

/* File: test/tb.sv */
// Self-checking testbench for the drive operating state sequencer
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic core_clk, arst_n, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address, avs_byteenable, drive_state_word;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic power_supply_ok, channel_valid, reference_rx, reference_zero, ramp_done;
  logic fault_detect, fault_resp_done, stop_key, term_freewheel, autotune_req;
  logic power_stage_ready, motor_power, output_voltage, contactor_close, ramp_decel;
  logic fast_ramp, coast, config_write_ok, adjust_write_ok, autotune_start;
  int error_cnt, n_tests, cyc, seed;

  dos_sequencer dut (.core_clk, .arst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .power_supply_ok, .channel_valid, .reference_rx, .reference_zero, .ramp_done,
    .fault_detect, .fault_resp_done, .stop_key, .term_freewheel, .autotune_req,
    .drive_state_word, .power_stage_ready, .motor_power, .output_voltage,
    .contactor_close, .ramp_decel, .fast_ramp, .coast, .config_write_ok,
    .adjust_write_ok, .autotune_start);
  dos_master m (.core_clk, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Limit sized well above the scripted run
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end

  function automatic logic exp_closed(input logic [3:0] s);
    return (s == dos_pkg::SW_ON) || (s == dos_pkg::SW_OPEN);
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic st(input logic [3:0] e);
    chk("state", {28'h0, drive_state_word}, {28'h0, e});
  endtask

  task automatic go(input logic [3:0] a, input logic [31:0] d);
    m.xfer(1'b1, a, d, q);
    repeat (4) @(posedge core_clk);
  endtask

  task automatic up5();
    go(dos_pkg::CTRL_OFS, 32'h0006);
    go(dos_pkg::CTRL_OFS, 32'h0007);
    go(dos_pkg::CTRL_OFS, 32'h000F);
  endtask

  task automatic stop_test();
    $display("mismatches %0d of %0d checks", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    seed = 32'hc9dc6290;
    {power_supply_ok, channel_valid, reference_rx, reference_zero, ramp_done} = 5'h00;
    {fault_detect, fault_resp_done, stop_key, term_freewheel, autotune_req} = 5'h00;
    arst_n = 1'b0;
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    // Initialisation must finish before the first check
    repeat (dos_pkg::INIT_CYCLES + 4) @(posedge core_clk);
    st(dos_pkg::SW_DIS);
    chk("lock2", {motor_power, power_stage_ready, config_write_ok, adjust_write_ok},
        4'h3);
    go(dos_pkg::CFG_OFS, 32'h0C);
    go(dos_pkg::CTRL_OFS, 32'h0006);
    st(dos_pkg::SW_RDY);
    chk("lock3", {motor_power, config_write_ok, adjust_write_ok}, 3'h3);
    chk("cont3", contactor_close, exp_closed(dos_pkg::SW_RDY));
    go(dos_pkg::CTRL_OFS, 32'h0007);
    st(dos_pkg::SW_RDY);
    @(posedge core_clk) power_supply_ok <= 1'b1;
    go(dos_pkg::CTRL_OFS, 32'h0007);
    st(dos_pkg::SW_ON);
    chk("on4", {contactor_close, power_stage_ready, output_voltage, motor_power},
        {exp_closed(dos_pkg::SW_ON), 3'h4});
    repeat (4) begin
      go(dos_pkg::PWRITE_OFS, $random(seed) & 32'hFFFF_FFFE);
      st(dos_pkg::SW_ON);
    end
    go(dos_pkg::CTRL_OFS, 32'h000F);
    st(dos_pkg::SW_ON);
    @(posedge core_clk) channel_valid <= 1'b1;
    go(dos_pkg::CTRL_OFS, 32'h000F);
    st(dos_pkg::SW_OPEN);
    chk("run5", {contactor_close, motor_power}, 2'h3);
    @(posedge core_clk) autotune_req <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("tune", autotune_start, 1'b1);
    autotune_req <= 1'b0;
    reference_zero <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("zref", motor_power, 1'b0);
    reference_zero <= 1'b0;
    go(dos_pkg::CTRL_OFS, 32'h010F);
    st(dos_pkg::SW_OPEN);
    chk("halt", motor_power, 1'b0);
    go(dos_pkg::CTRL_OFS, 32'h000F);
    go(dos_pkg::CFG_OFS, 32'h0D);
    go(dos_pkg::CTRL_OFS, 32'h0007);
    st(dos_pkg::SW_ON);
    chk("coast", coast, 1'b1);
    go(dos_pkg::PWRITE_OFS, 32'h1);
    st(dos_pkg::SW_DIS);
    up5();
    go(dos_pkg::CTRL_OFS, 32'h0002);
    st(dos_pkg::SW_QSTOP);
    chk("qs", {motor_power, fast_ramp, config_write_ok}, 3'h6);
    @(posedge core_clk) ramp_done <= 1'b1;
    repeat (4) @(posedge core_clk);
    st(dos_pkg::SW_DIS);
    ramp_done <= 1'b0;
    go(dos_pkg::CFG_OFS, 32'h1F);
    up5();
    st(dos_pkg::SW_ON);
    @(posedge core_clk) reference_rx <= 1'b1;
    @(posedge core_clk) reference_rx <= 1'b0;
    repeat (4) @(posedge core_clk);
    st(dos_pkg::SW_OPEN);
    go(dos_pkg::CTRL_OFS, 32'h0002);
    @(posedge core_clk) ramp_done <= 1'b1;
    repeat (4) @(posedge core_clk);
    st(dos_pkg::SW_QSTOP);
    term_freewheel <= 1'b1;
    repeat (4) @(posedge core_clk);
    st(dos_pkg::SW_DIS);
    {term_freewheel, ramp_done} <= 2'h0;
    up5();
    go(dos_pkg::CTRL_OFS, 32'h0002);
    st(dos_pkg::SW_QSTOP);
    @(posedge core_clk) stop_key <= 1'b1;
    repeat (4) @(posedge core_clk);
    st(dos_pkg::SW_DIS);
    stop_key <= 1'b0;
    up5();
    go(dos_pkg::CTRL_OFS, 32'h0007);
    st(dos_pkg::SW_OPEN);
    chk("ramp", ramp_decel, 1'b1);
    @(posedge core_clk) ramp_done <= 1'b1;
    repeat (4) @(posedge core_clk);
    st(dos_pkg::SW_ON);
    {ramp_done, fault_detect} <= 2'h1;
    repeat (4) @(posedge core_clk);
    st(dos_pkg::SW_FREACT);
    fault_resp_done <= 1'b1;
    repeat (4) @(posedge core_clk);
    st(dos_pkg::SW_FAULT);
    chk("flt8", {power_stage_ready, motor_power}, 2'h0);
    {fault_detect, fault_resp_done} <= 2'h0;
    go(dos_pkg::CTRL_OFS, 32'h0080);
    m.xfer(1'b0, dos_pkg::STAT_OFS, 32'h0, q);
    chk("stat", q, {28'h0, dos_pkg::SW_DIS});
    m.xfer(1'b0, 4'h2, 32'h0, q);
    chk("unmapped", q, 32'h0);
    stop_test();
  end
endmodule // tb

`default_nettype wire
